// *** rtl/wdt_top.sv ***
`timescale 1ns/1ps
module wdt_top (
	// clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            resetn,
	// axi4-lite write address
	input  wire logic [wdt_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]                      s_axi_awprot,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	// axi4-lite write data
	input  wire logic [wdt_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	// axi4-lite read address
	input  wire logic [wdt_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]                      s_axi_arprot,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	// axi4-lite read data
	output logic [wdt_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	// clock sources and cpu state
	input  wire logic [3:0]                      src_tick,
	input  wire logic                            cpu_debug,
	// watchdog events
	output logic                                 nmi_out,
	output logic                                 sys_reset_out
);
	import wdt_pkg::*;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0]  aw_addr_reg;
	logic         aw_full_reg;
	logic [31:0]  w_data_reg;
	logic [3:0]   w_strb_reg;
	logic         w_full_reg;
	logic         wr_en;
	logic         wr_hit;
	logic         unlocked;
	logic         restart_w;
	logic [31:0]  rd_word;
	logic         rd_hit;
	logic [15:0]  protection_key_reg;
	wdt_clkctl_t  clk_ctl_reg;
	wdt_mode_t    mode_reg;
	logic         stopped_reg;
	logic         stat_reg;
	logic [9:0]   cmp_reg;
	logic [9:0]   cnt_reg;
	logic         cnt_en;
	logic         cnt_tick;
	logic         match;
	logic         nmi_now;
	logic         rst_now;
	logic [15:0]  clk_word;
	logic [15:0]  ctl_word;
	logic [15:0]  cmp_word;
	logic [15:0]  clk_new;
	logic [15:0]  ctl_new;
	logic [15:0]  cmp_new;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction : merge16

	// ----------------------------------------------------------------
	// axi4-lite write channels
	// ----------------------------------------------------------------

	// write address capture
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_addr_reg   <= 32'h0000_0000;
			aw_full_reg   <= 1'b0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awready && s_axi_awvalid) begin
			aw_addr_reg   <= s_axi_awaddr;
			aw_full_reg   <= 1'b1;
			s_axi_awready <= 1'b0;
		end else if (wr_en) begin
			aw_full_reg   <= 1'b0;
		end else if (!aw_full_reg && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data capture
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			w_full_reg   <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wready && s_axi_wvalid) begin
			w_data_reg   <= s_axi_wdata;
			w_strb_reg   <= s_axi_wstrb;
			w_full_reg   <= 1'b1;
			s_axi_wready <= 1'b0;
		end else if (wr_en) begin
			w_full_reg   <= 1'b0;
		end else if (!w_full_reg && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// commit once address and data are both held
	assign wr_en  = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_hit = (aw_addr_reg == OFS_CLK_CTL) ||
		(aw_addr_reg == OFS_CONTROL) || (aw_addr_reg == OFS_COMPARE) ||
		(aw_addr_reg == OFS_PROTECT);

	// write response
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channels
	// ----------------------------------------------------------------

	// register images as software sees them
	assign clk_word = {7'h00, clk_ctl_reg.debug_run_enable, 2'h0, clk_ctl_reg.div,
		2'h0, clk_ctl_reg.src};
	assign ctl_word = {5'h00, mode_reg, stat_reg, 3'h0, 1'b0,
		stopped_reg ? RUN_STOP_KEY : RUN_READ_ON};
	assign cmp_word = {6'h00, cmp_reg};

	// read decode
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			OFS_CLK_CTL: rd_word = {16'h0000, clk_word};
			OFS_CONTROL: rd_word = {16'h0000, ctl_word};
			OFS_COMPARE: rd_word = {16'h0000, cmp_word};
			OFS_PROTECT: rd_word = {31'h0000_0000, unlocked};
			default:     rd_hit  = 1'b0;
		endcase
	end

	// read address and data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// protection and configuration registers
	// ----------------------------------------------------------------
	assign unlocked = (protection_key_reg == PROTECTION_KEY_KEY);
	assign clk_new  = merge16(clk_word, w_data_reg, w_strb_reg);
	assign ctl_new  = merge16(ctl_word, w_data_reg, w_strb_reg);
	assign cmp_new  = merge16(cmp_word, w_data_reg, w_strb_reg);

	// protection key, never itself locked
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			protection_key_reg <= PROTECTION_KEY_RST;
		end else if (wr_en && aw_addr_reg == OFS_PROTECT) begin
			protection_key_reg <= merge16(protection_key_reg, w_data_reg, w_strb_reg);
		end
	end

	// clock source, divider and debug-run
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_ctl_reg <= CLKCTL_RST;
		end else if (wr_en && unlocked && aw_addr_reg == OFS_CLK_CTL) begin
			clk_ctl_reg.debug_run_enable <= clk_new[CLK_DEBUG_RUN_ENABLE_BIT];
			clk_ctl_reg.div   <= clk_new[CLK_DIV_LSB +: 2];
			clk_ctl_reg.src   <= wdt_src_t'(clk_new[CLK_SRC_LSB +: 2]);
		end
	end

	// match mode and run key; the run key only acts on byte 0
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg    <= WDT_MODE_RESET;
			stopped_reg <= 1'b1;
		end else if (wr_en && unlocked && aw_addr_reg == OFS_CONTROL) begin
			mode_reg <= wdt_mode_t'(ctl_new[CTL_MODE_LSB +: 2]);
			if (w_strb_reg[0]) begin
				stopped_reg <= (ctl_new[CTL_RUN_LSB +: 4] ==
					RUN_STOP_KEY);
			end
		end
	end

	// compare value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_reg <= CMP_RST;
		end else if (wr_en && unlocked && aw_addr_reg == OFS_COMPARE) begin
			cmp_reg <= cmp_new[9:0];
		end
	end

	// restart strobe, write-only and protected
	assign restart_w = wr_en && unlocked && aw_addr_reg == OFS_CONTROL &&
		w_strb_reg[0] && w_data_reg[CTL_RST_BIT];

	// ----------------------------------------------------------------
	// counter clock
	// ----------------------------------------------------------------

	// debug freezes unless debug-run; halt and sleep do not gate
	assign cnt_en = !stopped_reg &&
		!(cpu_debug && !clk_ctl_reg.debug_run_enable);

	wdt_prescaler u_prescaler (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.clear    (restart_w),
		.enable   (cnt_en),
		.clk_ctl  (clk_ctl_reg),
		.src_tick (src_tick),
		.cnt_tick (cnt_tick)
	);

	// ----------------------------------------------------------------
	// counter, compare and events
	// ----------------------------------------------------------------
	assign match = cnt_tick && cnt_en && !restart_w &&
		(cnt_reg == cmp_reg);

	// action chosen by mode; reserved mode does nothing
	always_comb begin
		nmi_now = 1'b0;
		rst_now = 1'b0;
		unique case (mode_reg)
			WDT_MODE_RESET:   rst_now = match;
			WDT_MODE_NMI:     nmi_now = match;
			WDT_MODE_NMI_RST: begin
				nmi_now = match && !stat_reg;
				rst_now = match && stat_reg;
			end
			WDT_MODE_RSVD: begin
				nmi_now = 1'b0;
				rst_now = 1'b0;
			end
		endcase
	end

	// ten-bit up counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= CNT_RST;
		end else if (restart_w) begin
			cnt_reg <= CNT_RST;
		end else if (match) begin
			cnt_reg <= CNT_RST;
		end else if (cnt_tick && cnt_en) begin
			cnt_reg <= cnt_reg + 10'h001;
		end
	end

	// nmi status; a restart blocks the match in its cycle, so it wins over a new nmi
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= 1'b0;
		end else if (nmi_now) begin
			stat_reg <= 1'b1;
		end else if (restart_w) begin
			stat_reg <= 1'b0;
		end
	end

	// one-cycle event pulses to the system
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_out       <= 1'b0;
			sys_reset_out <= 1'b0;
		end else begin
			nmi_out       <= nmi_now;
			sys_reset_out <= rst_now;
		end
	end

endmodule : wdt_top

// *** rtl/wdt_pkg.sv ***
package wdt_pkg;

	// --------------------------------------------------------------
	// clock and bus constants
	// --------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ   = 200_000_000;
	localparam int unsigned AXI_ADDR_W    = 32;
	localparam int unsigned AXI_DATA_W    = 32;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [31:0] OFS_CLK_CTL   = 32'h0000_0000;
	localparam logic [31:0] OFS_CONTROL   = 32'h0000_0004;
	localparam logic [31:0] OFS_COMPARE   = 32'h0000_0008;
	localparam logic [31:0] OFS_PROTECT   = 32'h0000_000c;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int unsigned CLK_DEBUG_RUN_ENABLE_BIT = 8;
	localparam int unsigned CLK_DIV_LSB   = 4;
	localparam int unsigned CLK_SRC_LSB   = 0;
	localparam int unsigned CTL_MODE_LSB  = 9;
	localparam int unsigned CTL_STAT_BIT  = 8;
	localparam int unsigned CTL_RST_BIT   = 4;
	localparam int unsigned CTL_RUN_LSB   = 0;

	// --------------------------------------------------------------
	// keys and values after reset
	// --------------------------------------------------------------
	localparam int unsigned CNT_W         = 10;
	localparam logic [15:0] PROTECTION_KEY_KEY      = 16'h0096;
	localparam logic [15:0] PROTECTION_KEY_RST      = 16'h0000;
	localparam logic [3:0]  RUN_STOP_KEY  = 4'ha;
	localparam logic [3:0]  RUN_READ_ON   = 4'h0;
	localparam logic [9:0]  CMP_RST       = 10'h3ff;
	localparam logic [9:0]  CNT_RST       = 10'h000;

	// --------------------------------------------------------------
	// prescaler limits (ratio minus one)
	// --------------------------------------------------------------
	localparam int unsigned PRE_W         = 16;
	localparam logic [15:0] LIM_8192      = 16'h1fff;
	localparam logic [15:0] LIM_16384     = 16'h3fff;
	localparam logic [15:0] LIM_32768     = 16'h7fff;
	localparam logic [15:0] LIM_65536     = 16'hffff;
	localparam logic [15:0] LIM_128       = 16'h007f;
	localparam logic [15:0] LIM_1         = 16'h0000;
	localparam logic [15:0] PRE_RST       = 16'h0000;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		WDT_SRC_IOSC  = 2'h0,
		WDT_SRC_OSC1  = 2'h1,
		WDT_SRC_OSC3  = 2'h2,
		WDT_SRC_EXOSC = 2'h3
	} wdt_src_t;

	typedef enum logic [1:0] {
		WDT_MODE_RESET   = 2'h0,
		WDT_MODE_NMI     = 2'h1,
		WDT_MODE_NMI_RST = 2'h2,
		WDT_MODE_RSVD    = 2'h3
	} wdt_mode_t;

	typedef struct packed {
		logic     debug_run_enable;
		logic [1:0] div;
		wdt_src_t src;
	} wdt_clkctl_t;

	localparam wdt_clkctl_t CLKCTL_RST = '{debug_run_enable: 1'b0, div: 2'h0,
		src: WDT_SRC_IOSC};

endpackage : wdt_pkg

// *** rtl/wdt_prescaler.sv ***
`timescale 1ns/1ps
module wdt_prescaler (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	// control
	input  wire logic               clear,
	input  wire logic               enable,
	input  wdt_pkg::wdt_clkctl_t    clk_ctl,
	// source enables
	input  wire logic [3:0]         src_tick,
	// counter clock enable
	output logic                    cnt_tick
);
	import wdt_pkg::*;

	logic [PRE_W-1:0] pre_reg;

	// ratio minus one for a source and divider setting
	function automatic logic [PRE_W-1:0] limit_of(input wdt_src_t s,
		input logic [1:0] d);
		logic [PRE_W-1:0] r;
		r = LIM_1;
		unique case (s)
			WDT_SRC_IOSC, WDT_SRC_OSC3: begin
				unique case (d)
					2'h0: r = LIM_8192;
					2'h1: r = LIM_16384;
					2'h2: r = LIM_32768;
					2'h3: r = LIM_65536;
				endcase
			end
			WDT_SRC_OSC1:  r = LIM_128;
			WDT_SRC_EXOSC: r = LIM_1;
		endcase
		return r;
	endfunction : limit_of

	// divide the selected source; a stopped source stalls here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg  <= PRE_RST;
			cnt_tick <= 1'b0;
		end else if (clear) begin
			pre_reg  <= PRE_RST;
			cnt_tick <= 1'b0;
		end else if (enable && src_tick[clk_ctl.src]) begin
			if (pre_reg >= limit_of(clk_ctl.src, clk_ctl.div)) begin
				pre_reg  <= PRE_RST;
				cnt_tick <= 1'b1;
			end else begin
				pre_reg  <= pre_reg + 16'h0001;
				cnt_tick <= 1'b0;
			end
		end else begin
			cnt_tick <= 1'b0;
		end
	end

endmodule : wdt_prescaler

// *** testbench/wdt_top_properties.sv ***
`timescale 1ns/1ps
module wdt_top_properties (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        resetn,
	// bus handshakes
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// watchdog side
	input wire logic [3:0]  src_tick,
	input wire logic        nmi_out,
	input wire logic        sys_reset_out
);
	// ----------------------------------------------------------
	// properties
	// ----------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready during response");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during read data");
	a_bresp_code: assert property (s_axi_bvalid
		|-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
	a_one_event: assert property (!(nmi_out && sys_reset_out))
		else $error("nmi and reset together");
	a_event_tick: assert property (nmi_out || sys_reset_out
		|-> $past(src_tick != 4'h0, 2)) else $error("event without tick");
	a_sleep_quiet: assert property ((src_tick == 4'h0) [*3]
		|-> !nmi_out && !sys_reset_out) else $error("event with clock stopped");
endmodule : wdt_top_properties

bind wdt_top wdt_top_properties u_props (.sys_clk, .resetn, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .src_tick, .nmi_out,
	.sys_reset_out);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import wdt_pkg::*;
	// ----------------------------------------------------------
	// signals and model state
	// ----------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_rdata, r, m_clk = '0;
	logic [3:0]  s_axi_wstrb = 4'hf, src_tick = '0;
	logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, m_mode = '0;
	logic [9:0]  m_cmp = CMP_RST;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, cpu_debug = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, nmi_out, sys_reset_out, ev_rst;
	logic        ex_on = 0, o1_on = 0, rnd_on = 1, io_on = 0;
	logic        m_stat = 0, m_stop = 1, unl = 0;
	int          failures = 0, n_checks = 0, cyc = 0, c, n, md;
	int          seed = 32'hb228_2893;

	wdt_top uut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .src_tick, .cpu_debug, .nmi_out, .sys_reset_out);

	// clock, source pulses with random noise on unused sources, timeout
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		r = $random(seed);
		src_tick <= {ex_on, r[2] & rnd_on, o1_on, (r[0] & rnd_on) | io_on};
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk_val

	task chk_rng(input string nm, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			failures++;
			$display("wrong value %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : chk_rng

	// write one word, check response, update the model
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// wait for the response; only the bench timeout ends this
		do begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk_val("bresp", a > OFS_PROTECT ? RESP_SLVERR : RESP_OKAY, s_axi_bresp);
		if (a == OFS_PROTECT) unl = (d[15:0] == PROTECTION_KEY_KEY);
		else if (unl && a == OFS_CLK_CTL) m_clk = d & 32'h0000_0133;
		else if (unl && a == OFS_COMPARE) m_cmp = d[9:0];
		else if (unl && a == OFS_CONTROL) begin
			m_mode = d[10:9];
			m_stop = (d[3:0] == RUN_STOP_KEY);
			if (d[4]) m_stat = 1'b0;
		end
	endtask : wr

	// read one word and compare with the model
	task rd(input logic [31:0] a);
		logic [31:0] e;
		e = '0;
		if (a == OFS_CLK_CTL) e = m_clk;
		if (a == OFS_COMPARE) e = {22'h0, m_cmp};
		if (a == OFS_PROTECT) e = {31'h0, unl};
		if (a == OFS_CONTROL) e = {21'h0, m_mode, m_stat, 4'h0,
			m_stop ? RUN_STOP_KEY : RUN_READ_ON};
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// wait for read data; only the bench timeout ends this
		do begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk_val("rdata", e, s_axi_rdata);
		chk_val("rresp", a > OFS_PROTECT ? RESP_SLVERR : RESP_OKAY, s_axi_rresp);
	endtask : rd

	// cycles until the next nmi or reset pulse, -1 if none
	task wait_evt(input int lim, output int cnt);
		int t;
		cnt = -1;
		for (t = 1; t <= lim; t++) begin
			@(posedge sys_clk);
			if (nmi_out === 1'b1 || sys_reset_out === 1'b1) begin
				cnt = t;
				ev_rst = sys_reset_out;
				if (nmi_out === 1'b1) m_stat = 1'b1;
				break;
			end
		end
	endtask : wait_evt

	// restart together with run, in the given mode
	task go(input logic [1:0] m);
		wr(OFS_CONTROL, {21'h0, m, 9'h015});
	endtask : go

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(OFS_CLK_CTL);
		rd(OFS_CONTROL);
		rd(OFS_COMPARE);
		rd(OFS_PROTECT);
		rd(32'h0000_0010);
		wr(OFS_COMPARE, 32'h0000_0005);
		rd(OFS_COMPARE);
		wr(OFS_PROTECT, {16'h0, PROTECTION_KEY_KEY});
		c = 4 + ($random(seed) & 15);
		ex_on <= 1'b1;
		wr(OFS_CLK_CTL, 32'h0000_0003);
		wr(OFS_COMPARE, c);
		rd(OFS_COMPARE);
		// timing starts at the restart, so nothing between go and wait
		go(2'h1);
		wait_evt(c + 10, n);
		chk_rng("first nmi", c + 1, c + 5, n);
		chk_val("event kind", 1'b0, ev_rst);
		wait_evt(c + 10, n);
		chk_rng("nmi period", c + 1, c + 1, n);
		// freeze first so no unseen match falls inside the reads
		cpu_debug <= 1'b1;
		rd(OFS_CONTROL);
		rd(OFS_CONTROL);
		go(2'h1);
		rd(OFS_CONTROL);
		wait_evt(3 * c, n);
		chk_rng("debug hold", -1, -1, n);
		cpu_debug <= 1'b0;
		wait_evt(c + 10, n);
		chk_rng("debug resume", c + 1, c + 5, n);
		wr(OFS_CLK_CTL, 32'h0000_0103);
		rd(OFS_CLK_CTL);
		cpu_debug <= 1'b1;
		wait_evt(c + 10, n);
		wait_evt(c + 10, n);
		chk_rng("debug run", c + 1, c + 1, n);
		cpu_debug <= 1'b0;
		for (md = 0; md < 4; md++) begin
			go(2'(md));
			wait_evt(c + 10, n);
			chk_rng("mode first", md == 3 ? -1 : c + 1,
				md == 3 ? -1 : c + 5, n);
			if (md < 3) chk_val("mode kind", md == 0, ev_rst);
			if (md == 2) begin
				wait_evt(c + 10, n);
				chk_rng("second match", c + 1, c + 1, n);
				chk_val("second kind", 1'b1, ev_rst);
			end
		end
		wr(OFS_CONTROL, 32'h0000_020a);
		rd(OFS_CONTROL);
		wait_evt(3 * c, n);
		chk_rng("stopped", -1, -1, n);
		go(2'h1);
		ex_on <= 1'b0;
		rnd_on <= 1'b0;
		wait_evt(3 * c, n);
		chk_rng("source stopped", -1, -1, n);
		rnd_on <= 1'b1;
		o1_on <= 1'b1;
		wr(OFS_CLK_CTL, 32'h0000_0001);
		wr(OFS_COMPARE, 32'h0000_0003);
		go(2'h1);
		wait_evt(700, n);
		wait_evt(700, n);
		chk_rng("divided period", 512, 512, n);
		// internal source, smallest ratio, one tick per interval
		io_on <= 1'b1;
		wr(OFS_CLK_CTL, 32'h0000_0000);
		wr(OFS_COMPARE, 32'h0000_0000);
		go(2'h1);
		wait_evt(9000, n);
		wait_evt(9000, n);
		chk_rng("iosc period", 8192, 8192, n);
		wr(OFS_PROTECT, 32'h0000_0000);
		wr(OFS_CONTROL, 32'h0000_000a);
		rd(OFS_CONTROL);
		rd(OFS_PROTECT);
		report_and_stop();
	end
endmodule : tb_top
